// >>> hw/bis_status_reg.sv
// Bridge identity and status word with configuration address capture.
`timescale 1ns/1ps
module bis_status_reg
   import bis_pkg::*;
#(
   parameter logic [2:0] FUNC_NUM = BIS_FN_RST
)(
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        cfg_addr_valid,
   input  wire logic [3:0]  cfg_cmd,
   input  wire logic        cfg_idsel,
   input  wire logic [31:0] cfg_ad,
   input  wire logic        rd_en,
   input  wire logic [7:0]  rd_offset,
   input  wire logic [7:0]  prim_bus_num,
   input  wire logic        reverse_mode,
   input  wire logic        wide_capable_strap,
   input  wire logic        wide_request_n,
   output logic [31:0]      rd_data_q,
   output logic             rd_valid_q,
   output logic [15:0]      completer_id_q,
   output logic             wide_flag_q,
   output logic             fast_flag_q
);
   // =====================================================================
   // Declarations
   // =====================================================================
   logic [4:0]  dev_q;
   logic [4:0]  dev_d;
   logic [7:0]  bus_q;
   logic [7:0]  bus_d;
   logic [31:0] rd_data_d;
   logic        rd_valid_d;
   logic [15:0] completer_id_d;
   logic        hit;

   // Assembles the status word; used for the read data only.
   function automatic logic [31:0] status_word(input logic [7:0] bus,
                                               input logic [4:0] dev,
                                               input logic wide,
                                               input logic fast);
      logic [31:0] w;
      w = 32'h0;
      w[BIS_FN_LSB +: 3]  = FUNC_NUM;
      w[BIS_DEV_LSB +: 5] = dev;
      w[BIS_BUS_LSB +: 8] = bus;
      w[BIS_WIDE_BIT]     = wide;
      w[BIS_FAST_BIT]     = fast;
      return w;
   endfunction

   // =====================================================================
   // Strap capture
   // =====================================================================
   bis_strap_sampler u_strap (
      .clock              (clock),
      .nrst               (nrst),
      .reverse_mode       (reverse_mode),
      .wide_capable_strap (wide_capable_strap),
      .wide_request_n     (wide_request_n),
      .wide_flag_q        (wide_flag_q),
      .fast_flag_q        (fast_flag_q)
   );

   // =====================================================================
   // Address phase decode
   // =====================================================================
   // The decode relies on the host keeping the type 0 write format; any
   // other cycle, including type 1 or a read, leaves the device number.
   assign hit = cfg_addr_valid && cfg_cmd == BIS_CMD_CFG_WR && cfg_idsel
                && cfg_ad[1:0] == BIS_CFG_TYPE0
                && cfg_ad[10:8] == FUNC_NUM;

   // =====================================================================
   // Device number capture
   // =====================================================================
   // There is no write path into this word at all, so a software write to
   // offset 84h simply falls on the floor; only an addressing cycle moves
   // the device number.
   always_comb begin
      dev_d = dev_q;
      if (hit) begin
         dev_d = cfg_ad[15:11];
      end
   end

   // Device number register; reset leaves the all-ones number.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         dev_q <= BIS_DEV_RST;
      end else begin
         dev_q <= dev_d;
      end
   end

   // =====================================================================
   // Bus number mirror
   // =====================================================================
   // The copy costs one cycle of latency, which is harmless since software
   // changes the primary bus number far less often than it reads it.
   always_comb begin
      bus_d = prim_bus_num;
   end

   // Bus number register.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bus_q <= BIS_BUS_RST;
      end else begin
         bus_q <= bus_d;
      end
   end

   // =====================================================================
   // Read port
   // =====================================================================
   // Unmapped offsets still answer, with zero, so a host never waits on an
   // address that this block does not own.
   always_comb begin
      rd_valid_d = rd_en;
      rd_data_d  = 32'h0;
      if (rd_en && rd_offset == BIS_OFS_STATUS) begin
         rd_data_d = status_word(bus_q, dev_q, wide_flag_q, fast_flag_q);
      end
   end

   // Read answer registers.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rd_data_q  <= 32'h0;
         rd_valid_q <= 1'b0;
      end else begin
         rd_data_q  <= rd_data_d;
         rd_valid_q <= rd_valid_d;
      end
   end

   // =====================================================================
   // Completer ID
   // =====================================================================
   // Registered so the ID is a clean flop output; it trails a device number
   // capture by one cycle, which a split completion never notices.
   always_comb begin
      completer_id_d = {bus_q, dev_q, FUNC_NUM};
   end

   // Completer ID register.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         completer_id_q <= {BIS_BUS_RST, BIS_DEV_RST, BIS_FN_RST};
      end else begin
         completer_id_q <= completer_id_d;
      end
   end

   // =====================================================================
   // Checks
   // =====================================================================
   // Every check runs on the bus clock and is silent while reset is held;
   // the reset values are looked at on the first edge after release.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   // Reset values of the captured and mirrored fields.
   dev_reset_a: assert property (
      !$past(nrst) |-> dev_q == BIS_DEV_RST)
      else $error("device number reset value wrong");
   bus_reset_a: assert property (
      !$past(nrst) |-> bus_q == BIS_BUS_RST)
      else $error("bus number reset value wrong");
   id_reset_a: assert property (
      !$past(nrst) |-> completer_id_q
      == {BIS_BUS_RST, BIS_DEV_RST, BIS_FN_RST})
      else $error("completer id reset value wrong");

   // Device number capture, and no movement without an addressing write.
   dev_capture_a: assert property (
      hit |=> dev_q == $past(cfg_ad[15:11]))
      else $error("device number not captured");
   dev_hold_a: assert property (
      !hit |=> $stable(dev_q))
      else $error("device number moved without a write");

   // Fields of a read answer, one cycle after the request.
   func_field_a: assert property (
      rd_en && rd_offset == BIS_OFS_STATUS |=> rd_data_q[2:0] == FUNC_NUM)
      else $error("function field wrong");
   dev_read_a: assert property (
      rd_en && rd_offset == BIS_OFS_STATUS
      |=> rd_data_q[7:3] == $past(dev_q))
      else $error("device number read mismatch");
   // A read in the first cycle after release still shows the reset bus
   // number, so this check starts one edge later.
   bus_read_a: assert property (
      rd_en && rd_offset == BIS_OFS_STATUS && $stable(prim_bus_num)
      && $past(nrst) |=> rd_valid_q
      && rd_data_q[15:8] == $past(prim_bus_num))
      else $error("bus number read mismatch");
   flag_read_a: assert property (
      rd_en && rd_offset == BIS_OFS_STATUS
      |=> rd_data_q[17:16] == {$past(fast_flag_q), $past(wide_flag_q)})
      else $error("flag bits read mismatch");
   read_timing_a: assert property (
      rd_en |=> rd_valid_q ##0 (rd_data_q[31:18] == 14'h0))
      else $error("read answer late or reserved bits set");

   // The completer ID follows the fields one cycle behind.
   cmpl_id_a: assert property (
      1'b1 |=> completer_id_q == {$past(bus_q), $past(dev_q), FUNC_NUM})
      else $error("completer id mismatch");

   // Strap flags, caught at the first edge after release.
   wide_strap_a: assert property (
      !wide_capable_strap |=> !wide_flag_q || $past(wide_flag_q))
      else $error("wide flag set without strap");
   wide_fwd_a: assert property (
      !reverse_mode [*3] |-> !wide_flag_q && !fast_flag_q
      || $past(reverse_mode, 3))
      else $error("forward mode flags not zero");
   wide_high_a: assert property (
      !$past(nrst) && reverse_mode && wide_request_n |=> !wide_flag_q)
      else $error("wide flag set with request high");
   wide_rev_a: assert property (
      !$past(nrst) && reverse_mode && wide_capable_strap && !wide_request_n
      |=> wide_flag_q)
      else $error("reverse mode wide flag not set");
   fast_rev_a: assert property (
      !$past(nrst) |=> fast_flag_q == $past(reverse_mode))
      else $error("fast flag does not follow the mode");
endmodule

// >>> hw/bis_pkg.sv
// Package with offsets, field layout and reset values of the bridge status word.
package bis_pkg;
   // =====================================================================
   // Register map
   // =====================================================================
   localparam logic [7:0] BIS_OFS_STATUS  = 8'h84;
   // =====================================================================
   // Field positions of the status word
   // =====================================================================
   localparam int         BIS_FN_LSB      = 0;
   localparam int         BIS_DEV_LSB     = 3;
   localparam int         BIS_BUS_LSB     = 8;
   localparam int         BIS_WIDE_BIT    = 16;
   localparam int         BIS_FAST_BIT    = 17;
   // =====================================================================
   // Reset values
   // =====================================================================
   localparam logic [2:0] BIS_FN_RST      = 3'h0;
   localparam logic [4:0] BIS_DEV_RST     = 5'h1f;
   localparam logic [7:0] BIS_BUS_RST     = 8'hff;
   // =====================================================================
   // Address phase decoding
   // =====================================================================
   localparam logic [3:0] BIS_CMD_CFG_WR  = 4'hb;
   localparam logic [1:0] BIS_CFG_TYPE0   = 2'h0;
endpackage

// >>> hw/bis_strap_sampler.sv
// Catches the mode and wide-request straps once, just after reset release.
`timescale 1ns/1ps
module bis_strap_sampler
   import bis_pkg::*;
(
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic reverse_mode,
   input  wire logic wide_capable_strap,
   input  wire logic wide_request_n,
   output logic      wide_flag_q,
   output logic      fast_flag_q
);
   logic done_q;
   logic done_d;
   logic wide_flag_d;
   logic fast_flag_d;

   // =====================================================================
   // Capture at the first edge after release
   // =====================================================================
   // The async reset may only load constants, so the straps are caught by
   // the first clock edge after nrst rises and then frozen.
   always_comb begin
      done_d      = 1'b1;
      wide_flag_d = wide_flag_q;
      fast_flag_d = fast_flag_q;
      if (!done_q) begin
         wide_flag_d = reverse_mode & wide_capable_strap
                       & ~wide_request_n;
         fast_flag_d = reverse_mode;
      end
   end

   // Registers only.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         done_q      <= 1'b0;
         wide_flag_q <= 1'b0;
         fast_flag_q <= 1'b0;
      end else begin
         done_q      <= done_d;
         wide_flag_q <= wide_flag_d;
         fast_flag_q <= fast_flag_d;
      end
   end

   // Once captured, the flags never move again.
   wide_frozen_a: assert property (
      @(posedge clock) disable iff (!nrst)
      done_q |=> $stable(wide_flag_q) && $stable(fast_flag_q))
      else $error("strap flags changed after capture");
endmodule

// >>> verif/bis_cfg_host.sv
// Configuration master model that drives address phases into the block.
`timescale 1ns/1ps
module bis_cfg_host (
   input  wire logic        clock,
   output logic             cfg_addr_valid,
   output logic [3:0]       cfg_cmd,
   output logic             cfg_idsel,
   output logic [31:0]      cfg_ad
);
   // Idle bus: no strobe, and AD is not left at a clean zero.
   initial begin
      cfg_addr_valid = 1'b0;
      cfg_cmd = 4'h0;
      cfg_idsel = 1'b0;
      cfg_ad = 32'h5a5a_a5a5;
   end
   // One address phase, launched just after an edge and held to the next.
   task automatic addr_phase(input logic [3:0] cmd, input logic sel,
                             input logic [31:0] ad);
      #1;
      cfg_addr_valid = 1'b1;
      cfg_cmd = cmd;
      cfg_idsel = sel;
      cfg_ad = ad;
      @(posedge clock);
      #1;
      cfg_addr_valid = 1'b0;
      cfg_idsel = 1'b0;
      // Released AD shows the inverse, so a stale capture cannot hide.
      cfg_ad = ~ad;
   endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the bridge identity status word.
`timescale 1ns/1ps
module tb_top;
   import bis_pkg::*;
   logic        clock, nrst, rd_en, rd_valid_q, wide_flag_q, fast_flag_q;
   logic        reverse_mode, wide_capable_strap, wide_request_n;
   logic        cfg_addr_valid, cfg_idsel;
   logic [3:0]  cfg_cmd;
   logic [7:0]  rd_offset, prim_bus_num;
   logic [31:0] cfg_ad, rd_data_q, seed, ad;
   logic [15:0] completer_id_q;
   logic [4:0]  dev_m;
   logic        exp_w;
   int          err_total, cmp_count, i;
   // ==================================================================
   // Instances
   // ==================================================================
   bis_status_reg u_dut (.clock(clock), .nrst(nrst),
      .cfg_addr_valid(cfg_addr_valid), .cfg_cmd(cfg_cmd),
      .cfg_idsel(cfg_idsel), .cfg_ad(cfg_ad), .rd_en(rd_en),
      .rd_offset(rd_offset), .prim_bus_num(prim_bus_num),
      .reverse_mode(reverse_mode), .wide_capable_strap(wide_capable_strap),
      .wide_request_n(wide_request_n), .rd_data_q(rd_data_q),
      .rd_valid_q(rd_valid_q), .completer_id_q(completer_id_q),
      .wide_flag_q(wide_flag_q), .fast_flag_q(fast_flag_q));
   bis_cfg_host u_host (.clock(clock), .cfg_addr_valid(cfg_addr_valid),
      .cfg_cmd(cfg_cmd), .cfg_idsel(cfg_idsel), .cfg_ad(cfg_ad));
   // ==================================================================
   // Helpers and reference model
   // ==================================================================
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // Expected word; bits 31:18 stay zero since no split flags exist here.
   function automatic logic [31:0] word(input logic w, input logic f);
      return {14'h0, f, w, prim_bus_num, dev_m, BIS_FN_RST};
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task automatic end_sim;
      $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // A read is taken at one edge and answered just after it.
   task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
      @(posedge clock);
      #1;
      rd_en = 1'b1;
      rd_offset = ofs;
      @(posedge clock);
      #1;
      rd_en = 1'b0;
      chk("rd_valid_q", 32'h1, {31'h0, rd_valid_q});
      chk("rd_data_q", exp, rd_data_q);
      // The answer is a one-cycle pulse and must be gone one edge later.
      @(posedge clock);
      #1;
      chk("rd_valid_q", 32'h0, {31'h0, rd_valid_q});
   endtask
   // Straps are set during reset so the first clock edge after release samples them.
   task automatic reset_dut(input logic rev, strap, reqn);
      nrst = 1'b0;
      reverse_mode = rev;
      wide_capable_strap = strap;
      wide_request_n = reqn;
      seed = xs(seed);
      prim_bus_num = seed[7:0];
      dev_m = BIS_DEV_RST;
      repeat (2) @(posedge clock);
      #1;
      chk("completer_id_q", 32'hfff8, {16'h0, completer_id_q});
      nrst = 1'b1;
   endtask
   // ==================================================================
   // Clock, watchdog and tests
   // ==================================================================
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      #400000;
      err_total++;
      end_sim();
   end
   initial begin
      err_total = 0;
      cmp_count = 0;
      seed = 32'h6120;
      rd_en = 1'b0;
      rd_offset = 8'h0;
      for (i = 0; i < 8; i++) begin
         reset_dut(i[2], i[1], i[0]);
         exp_w = i[2] & i[1] & ~i[0];
         rd(8'h84, word(exp_w, i[2]));
         chk("wide_flag_q", {31'h0, exp_w}, {31'h0, wide_flag_q});
         chk("fast_flag_q", {31'h0, i[2]}, {31'h0, fast_flag_q});
      end
      $display("strap and reset test done");
      // Kinds 1 to 4 each break one addressing condition and must not load.
      for (i = 0; i < 40; i++) begin
         seed = xs(seed);
         ad = {seed[31:11], BIS_FN_RST, seed[7:2], 2'h0};
         if (i % 5 == 3) ad[1:0] = 2'h1;
         if (i % 5 == 4) ad[10:8] = BIS_FN_RST + 3'h1;
         if (i % 5 == 0) dev_m = ad[15:11];
         @(posedge clock);
         u_host.addr_phase((i % 5 == 1) ? 4'ha : BIS_CMD_CFG_WR,
                           i % 5 != 2, ad);
         repeat (2) @(posedge clock);
         #1;
         chk("completer_id_q", {16'h0, prim_bus_num, dev_m, BIS_FN_RST},
             {16'h0, completer_id_q});
         rd(8'h84, word(1'b0, 1'b1));
      end
      $display("device capture test done");
      rd(8'h80, 32'h0);
      rd(8'h88, 32'h0);
      $display("unmapped read test done");
      end_sim();
   end
endmodule
